// *** logic/etc_core.sv ***
// Eight-bit timer/counter core with two compare units
//
// How it works
// - Counter and both compares are eight bits.
// - Flags readable, each gated by mask bit.
// - Sources: overflow, match A, match B.
// - Select prescaled or external clock and edge.
// - Clock select zero stops the counter.
// - Each tick clears, increments or decrements.
// - Software reads and writes counter anytime.
// - Software counter write beats count or clear.
// - Bottom indicated when counter becomes 0x00.
// - Maximum reached when counter becomes 0xFF.
// - Top is 0xFF or compare A, by mode.
// - Three-bit wave mode split over controls A, B.
// - Compare continuously; match sets its flag.
// - Compare results feed the wave outputs.
// - Overflow flag set per wave mode.
// - Match flag one tick later; write one clears.
// - Mode zero counts up, wraps, flags at zero.
`timescale 1ns/1ns
module etc_core
    import etc_pkg::*;
#(
    parameter int DATA_W = ETC_DATA_W
) (
    input  wire logic              sys_clk_in,
    input  wire logic              reset_n_in,
    input  wire logic [3:0]        addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    input  wire logic              ext_count_pin_in,
    output logic [DATA_W-1:0]      rdata_out,
    output logic                   irq_out,
    output logic                   wave_out_a_out,
    output logic                   wave_out_b_out,
    output logic                   bottom_out,
    output logic                   max_out,
    output logic                   top_out
);

    etc_bus_req_t      req;
    etc_events_t       ev;

    logic [DATA_W-1:0] count_value_r;
    logic [DATA_W-1:0] count_value_nxt;
    logic [DATA_W-1:0] compare_value_a_r;
    logic [DATA_W-1:0] compare_value_b_r;
    logic [DATA_W-1:0] cmp_buf_a_r;
    logic [DATA_W-1:0] cmp_buf_b_r;
    logic [1:0]        control_reg_a_r;
    logic [3:0]        control_reg_b_r;
    logic [2:0]        irq_mask_reg_r;
    logic [2:0]        irq_flag_reg_r;
    logic [2:0]        irq_flag_nxt;
    logic              count_down_r;
    logic              match_a_pend_r;
    logic              match_b_pend_r;
    logic              block_match_r;
    logic [DATA_W-1:0] rdata_nxt;

    logic              timer_tick;
    logic [2:0]        wave_mode_field;
    logic [2:0]        clock_select_field;
    logic              pwm_mode;
    logic              phase_mode;
    logic [DATA_W-1:0] top_value;
    logic              at_top;
    logic              at_bottom;
    logic              cmp_eq_a;
    logic              cmp_eq_b;
    logic              wr_count;
    logic              wr_flags;
    logic              next_down;
    logic              reload;

    assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

    function automatic logic hit(input etc_bus_req_t r, input logic [3:0] off);
        hit = (r.addr == off);
    endfunction : hit

    // Wave mode pieces: two bits in control A, top bit in control B
    assign wave_mode_field    = {control_reg_b_r[ETC_WAVE_HI_POS],
                                 control_reg_a_r[1:0]};
    assign clock_select_field = control_reg_b_r[2:0];
    assign pwm_mode   = (wave_mode_field != ETC_WM_NORMAL) && (wave_mode_field != ETC_WM_CTC);
    assign phase_mode = (wave_mode_field == ETC_WM_PC_MAX) || (wave_mode_field == ETC_WM_PC_CMP);

    // Compare A provides top in CTC and the compare-top PWM modes
    assign top_value = (wave_mode_field == ETC_WM_CTC || wave_mode_field == ETC_WM_PC_CMP ||
                        wave_mode_field == ETC_WM_FAST_CMP)
                       ? compare_value_a_r : ETC_MAX;
    assign at_top    = (count_value_r == top_value);
    assign at_bottom = (count_value_r == ETC_BOTTOM);
    assign cmp_eq_a  = (count_value_r == compare_value_a_r);
    assign cmp_eq_b  = (count_value_r == compare_value_b_r);

    assign wr_count = hit(req, ETC_OFF_COUNT) && req.wr;
    assign wr_flags = hit(req, ETC_OFF_IRQ_FLAG) && req.wr;

    etc_tick_sel u_tick_sel (
        .sys_clk_in       (sys_clk_in),
        .reset_n_in       (reset_n_in),
        .clock_select_in  (clock_select_field),
        .ext_count_pin_in (ext_count_pin_in),
        .timer_tick_out   (timer_tick)
    );

    // Direction for phase-correct modes turns at top and bottom
    assign next_down = phase_mode ? (at_top ? 1'b1 : (at_bottom ? 1'b0 : count_down_r)) : 1'b0;

    // Software write wins over any tick action
    always_comb begin
        count_value_nxt = count_value_r;
        if (wr_count) begin
            count_value_nxt = req.wdata;
        end else if (timer_tick) begin
            if (phase_mode) begin
                count_value_nxt = next_down ? count_value_r - 8'h01
                                            : count_value_r + 8'h01;
            end else if (at_top) begin
                count_value_nxt = ETC_BOTTOM;
            end else begin
                count_value_nxt = count_value_r + 8'h01;
            end
        end
    end

    // Event raise: overflow per mode; match one tick after equality
    assign ev.overflow = timer_tick && !wr_count &&
                         (phase_mode ? (at_bottom && count_down_r)
                          : (wave_mode_field == ETC_WM_CTC ? (count_value_r == ETC_MAX)
                             : at_top));
    assign ev.match_a  = timer_tick && match_a_pend_r;
    assign ev.match_b  = timer_tick && match_b_pend_r;

    // Write one clears; a simultaneous set wins
    assign irq_flag_nxt = (irq_flag_reg_r & ~(wr_flags ? req.wdata[2:0] : 3'h0))
                          | {ev.match_b, ev.match_a, ev.overflow};

    // Double-buffered compares load at top in PWM modes
    assign reload = !pwm_mode || (timer_tick && (phase_mode ? at_top : at_top));

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_value_r <= ETC_RESET_VAL;
            count_down_r  <= 1'b0;
        end else begin
            count_value_r <= count_value_nxt;
            if (timer_tick && !wr_count) begin
                count_down_r <= next_down;
            end
        end
    end

    // Compare equality latched, shown on the next tick; counter write blocks it
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            match_a_pend_r <= 1'b0;
            match_b_pend_r <= 1'b0;
            block_match_r  <= 1'b0;
        end else begin
            if (wr_count) begin
                block_match_r <= 1'b1;
            end else if (timer_tick) begin
                block_match_r <= 1'b0;
            end
            match_a_pend_r <= cmp_eq_a && !block_match_r && !wr_count;
            match_b_pend_r <= cmp_eq_b && !block_match_r && !wr_count;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            control_reg_a_r   <= 2'h0;
            control_reg_b_r   <= 4'h0;
            cmp_buf_a_r       <= ETC_RESET_VAL;
            cmp_buf_b_r       <= ETC_RESET_VAL;
            compare_value_a_r <= ETC_RESET_VAL;
            compare_value_b_r <= ETC_RESET_VAL;
            irq_mask_reg_r    <= 3'h0;
            irq_flag_reg_r    <= 3'h0;
        end else begin
            if (req.wr && hit(req, ETC_OFF_CTRL_A)) begin
                control_reg_a_r <= req.wdata[1:0];
            end
            if (req.wr && hit(req, ETC_OFF_CTRL_B)) begin
                control_reg_b_r <= req.wdata[3:0];
            end
            if (req.wr && hit(req, ETC_OFF_CMP_A)) begin
                cmp_buf_a_r <= req.wdata;
            end
            if (req.wr && hit(req, ETC_OFF_CMP_B)) begin
                cmp_buf_b_r <= req.wdata;
            end
            if (req.wr && hit(req, ETC_OFF_IRQ_MASK)) begin
                irq_mask_reg_r <= req.wdata[2:0];
            end
            if (reload) begin
                compare_value_a_r <= (req.wr && hit(req, ETC_OFF_CMP_A) && !pwm_mode)
                                     ? req.wdata : cmp_buf_a_r;
                compare_value_b_r <= (req.wr && hit(req, ETC_OFF_CMP_B) && !pwm_mode)
                                     ? req.wdata : cmp_buf_b_r;
            end
            irq_flag_reg_r <= irq_flag_nxt;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        case (req.addr)
            ETC_OFF_CTRL_A:   rdata_nxt = {6'h00, control_reg_a_r};
            ETC_OFF_CTRL_B:   rdata_nxt = {4'h0, control_reg_b_r};
            ETC_OFF_COUNT:    rdata_nxt = count_value_r;
            ETC_OFF_CMP_A:    rdata_nxt = cmp_buf_a_r;
            ETC_OFF_CMP_B:    rdata_nxt = cmp_buf_b_r;
            ETC_OFF_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_reg_r};
            ETC_OFF_IRQ_FLAG: rdata_nxt = {5'h00, irq_flag_reg_r};
            default:          rdata_nxt = 8'h00;
        endcase
    end

    // Outputs all registered; wave outputs show compare equality, or count below compare in PWM modes
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out      <= 8'h00;
            irq_out        <= 1'b0;
            wave_out_a_out <= 1'b0;
            wave_out_b_out <= 1'b0;
            bottom_out     <= 1'b0;
            max_out        <= 1'b0;
            top_out        <= 1'b0;
        end else begin
            rdata_out      <= req.rd ? rdata_nxt : 8'h00;
            irq_out        <= |(irq_flag_nxt & irq_mask_reg_r);
            wave_out_a_out <= pwm_mode ? (count_value_nxt < compare_value_a_r)
                                       : cmp_eq_a;
            wave_out_b_out <= pwm_mode ? (count_value_nxt < compare_value_b_r)
                                       : cmp_eq_b;
            bottom_out     <= (count_value_nxt == ETC_BOTTOM);
            max_out        <= (count_value_nxt == ETC_MAX);
            top_out        <= (count_value_nxt == top_value);
        end
    end

endmodule : etc_core

// *** logic/etc_pkg.sv ***
// Shared constants and types of the eight-bit timer/counter core
package etc_pkg;

    localparam int          ETC_DATA_W       = 8;
    localparam int          ETC_ADDR_W       = 4;

    // Register offsets
    localparam logic [3:0]  ETC_OFF_CTRL_A   = 4'h0;
    localparam logic [3:0]  ETC_OFF_CTRL_B   = 4'h1;
    localparam logic [3:0]  ETC_OFF_COUNT    = 4'h2;
    localparam logic [3:0]  ETC_OFF_CMP_A    = 4'h3;
    localparam logic [3:0]  ETC_OFF_CMP_B    = 4'h4;
    localparam logic [3:0]  ETC_OFF_IRQ_MASK = 4'h5;
    localparam logic [3:0]  ETC_OFF_IRQ_FLAG = 4'h6;

    // Field positions
    localparam int          ETC_WAVE_LO_POS  = 0;
    localparam int          ETC_WAVE_HI_POS  = 3;
    localparam int          ETC_CS_POS       = 0;
    localparam int          ETC_OVF_POS      = 0;
    localparam int          ETC_MATCH_A_POS  = 1;
    localparam int          ETC_MATCH_B_POS  = 2;

    // Reset values and limits
    localparam logic [7:0]  ETC_RESET_VAL    = 8'h00;
    localparam logic [7:0]  ETC_BOTTOM       = 8'h00;
    localparam logic [7:0]  ETC_MAX          = 8'hff;

    // Clock select codes
    localparam logic [2:0]  ETC_CS_STOP      = 3'h0;
    localparam logic [2:0]  ETC_CS_PRE1      = 3'h1;
    localparam logic [2:0]  ETC_CS_PRE8      = 3'h2;
    localparam logic [2:0]  ETC_CS_PRE64     = 3'h3;
    localparam logic [2:0]  ETC_CS_PRE256    = 3'h4;
    localparam logic [2:0]  ETC_CS_PRE1024   = 3'h5;
    localparam logic [2:0]  ETC_CS_EXT_FALL  = 3'h6;
    localparam logic [2:0]  ETC_CS_EXT_RISE  = 3'h7;

    // Wave modes
    localparam logic [2:0]  ETC_WM_NORMAL    = 3'h0;
    localparam logic [2:0]  ETC_WM_PC_MAX    = 3'h1;
    localparam logic [2:0]  ETC_WM_CTC       = 3'h2;
    localparam logic [2:0]  ETC_WM_FAST_MAX  = 3'h3;
    localparam logic [2:0]  ETC_WM_PC_CMP    = 3'h5;
    localparam logic [2:0]  ETC_WM_FAST_CMP  = 3'h7;

    localparam logic [9:0]  ETC_PRE_WRAP     = 10'h3ff;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } etc_bus_req_t;

    typedef struct packed {
        logic match_b;
        logic match_a;
        logic overflow;
    } etc_events_t;

endpackage : etc_pkg

// *** logic/etc_tick_sel.sv ***
// Timer tick source: prescaler taps and synchronised external pin
`timescale 1ns/1ns
module etc_tick_sel
    import etc_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic [2:0] clock_select_in,
    input  wire logic       ext_count_pin_in,
    output logic            timer_tick_out
);

    logic [9:0] pre_cnt_r;
    logic [2:0] ext_sync_r;
    logic       ext_level_r;
    logic       tick_nxt;
    logic       ext_rise;
    logic       ext_fall;
    logic       ext_agree;

    // Free-running prescaler; taps are one-cycle pulses
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_cnt_r <= 10'h000;
        end else begin
            pre_cnt_r <= (pre_cnt_r == ETC_PRE_WRAP) ? 10'h000 : pre_cnt_r + 10'h001;
        end
    end

    // Three-stage pin sampler; level changes once stages two and three agree
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_sync_r  <= 3'h0;
            ext_level_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], ext_count_pin_in};
            if (ext_agree) begin
                ext_level_r <= ext_sync_r[2];
            end
        end
    end

    assign ext_agree = (ext_sync_r[1] == ext_sync_r[2]);
    assign ext_rise  = ext_agree && ext_sync_r[2] && !ext_level_r;
    assign ext_fall  = ext_agree && !ext_sync_r[2] && ext_level_r;

    always_comb begin
        case (clock_select_in)
            ETC_CS_STOP:     tick_nxt = 1'b0;
            ETC_CS_PRE1:     tick_nxt = 1'b1;
            ETC_CS_PRE8:     tick_nxt = (pre_cnt_r[2:0] == 3'h7);
            ETC_CS_PRE64:    tick_nxt = (pre_cnt_r[5:0] == 6'h3f);
            ETC_CS_PRE256:   tick_nxt = (pre_cnt_r[7:0] == 8'hff);
            ETC_CS_PRE1024:  tick_nxt = (pre_cnt_r == ETC_PRE_WRAP);
            ETC_CS_EXT_FALL: tick_nxt = ext_fall;
            ETC_CS_EXT_RISE: tick_nxt = ext_rise;
            default:         tick_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timer_tick_out <= 1'b0;
        end else begin
            timer_tick_out <= tick_nxt;
        end
    end

endmodule : etc_tick_sel

// *** verification/etc_core_checker.sv ***
// Port-level assertions for the eight-bit timer/counter core
`timescale 1ns/1ns
module etc_core_checker
    import etc_pkg::*;
#(
    parameter int DATA_W = ETC_DATA_W
) (
    input wire logic              sys_clk_in,
    input wire logic              reset_n_in,
    input wire logic [3:0]        addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic              irq_out,
    input wire logic              bottom_out,
    input wire logic              max_out,
    input wire logic              top_out
);
    logic [2:0] cs_r;
    logic [2:0] wm_r;
    logic [2:0] mask_r;
    logic [1:0] cfg_age_r;
    wire        cfg_wr  = wr_in && addr_in <= ETC_OFF_CTRL_B;
    wire        cnt_wr  = wr_in && addr_in == ETC_OFF_COUNT;
    wire        cnt_rd  = rd_in && addr_in == ETC_OFF_COUNT;
    // Settled config only: the tick path lags a select write
    wire        stopped = cs_r == ETC_CS_STOP && cfg_age_r == 2'h3;
    wire        run_all = cs_r == ETC_CS_PRE1 && wm_r == ETC_WM_NORMAL && cfg_age_r == 2'h3;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cs_r      <= ETC_CS_STOP;
            wm_r      <= ETC_WM_NORMAL;
            mask_r    <= 3'h0;
            cfg_age_r <= 2'h0;
        end else begin
            if (wr_in && addr_in == ETC_OFF_CTRL_A) wm_r[1:0] <= wdata_in[1:0];
            if (wr_in && addr_in == ETC_OFF_CTRL_B) wm_r[2] <= wdata_in[ETC_WAVE_HI_POS];
            if (wr_in && addr_in == ETC_OFF_CTRL_B) cs_r <= wdata_in[2:0];
            if (wr_in && addr_in == ETC_OFF_IRQ_MASK) mask_r <= wdata_in[2:0];
            cfg_age_r <= cfg_wr ? 2'h0 : cfg_age_r + {1'b0, cfg_age_r != 2'h3};
        end
    end

    default clocking dflt_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence cnt_set_stopped;
        cnt_wr && stopped ##1 cnt_rd;
    endsequence
    sequence cnt_set_running;
        cnt_wr && run_all ##1 cnt_rd;
    endsequence
    sequence quiet_at_max;
        (run_all && !wr_in) [*3] ##0 max_out;
    endsequence

    read_idle_zero_a: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    count_readback_a: assert property (cnt_set_stopped |=> rdata_out == $past(wdata_in, 2))
        else $error("stopped counter lost its written value");
    write_wins_a: assert property (cnt_set_running |=> rdata_out == $past(wdata_in, 2))
        else $error("counter write did not override the tick");
    stop_holds_a: assert property ((stopped && !wr_in) [*4] |=> $stable(bottom_out) && $stable(max_out))
        else $error("stopped counter moved");
    wrap_bottom_a: assert property (quiet_at_max |=> bottom_out)
        else $error("counter did not wrap from max to bottom");
    ends_exclusive_a: assert property (!(bottom_out && max_out))
        else $error("bottom and max both high");
    irq_masked_a: assert property ((mask_r == 3'h0) [*2] |-> !irq_out)
        else $error("irq high with all sources masked");
    max_top_a: assert property (wm_r == ETC_WM_NORMAL && cfg_age_r == 2'h3 && max_out |-> top_out)
        else $error("top missing at max in normal mode");
endmodule : etc_core_checker

bind etc_core etc_core_checker #(.DATA_W(DATA_W)) i_etc_core_checker (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .bottom_out(bottom_out), .max_out(max_out), .top_out(top_out));

// *** verification/eight_bit_timer_counter_core_test.sv ***
// Self-checking bench for the eight-bit timer/counter core
`timescale 1ns/1ns
module eight_bit_timer_counter_core_test;
    import etc_pkg::*;
    typedef struct {logic [7:0] lo; logic [7:0] hi;} etc_exp_t;
    logic       sys_clk_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic [3:0] addr_in    = 4'h0;
    logic [7:0] wdata_in   = 8'h00;
    logic       wr_in      = 1'b0;
    logic       rd_in      = 1'b0;
    logic       ext_count_pin_in = 1'b0;
    logic [7:0] rdata_out;
    logic       irq_out, wave_out_a_out, wave_out_b_out, bottom_out, max_out, top_out;
    logic       rd_seen = 1'b0;
    int         error_cnt = 0;
    int         num_checks = 0;
    etc_exp_t   exp_q[$];
    etc_exp_t   e;
    logic [7:0] v;
    logic [7:0] pre_exp [4] = '{8'h82, 8'h10, 8'h04, 8'h01};

    etc_core i_etc_core (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ext_count_pin_in(ext_count_pin_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .wave_out_a_out(wave_out_a_out),
        .wave_out_b_out(wave_out_b_out), .bottom_out(bottom_out), .max_out(max_out),
        .top_out(top_out));

    always #4 sys_clk_in = ~sys_clk_in;

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // Strobe stays high at task end so back-to-back calls never double-drive it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_in  <= a;
        wdata_in <= d;
        rd_in    <= 1'b0;
        wr_in    <= 1'b1;
        @(posedge sys_clk_in);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi);
        addr_in <= a;
        wr_in   <= 1'b0;
        rd_in   <= 1'b1;
        exp_q.push_back('{lo, hi});
        @(posedge sys_clk_in);
    endtask : rd

    task automatic idle(input int n);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (n) @(posedge sys_clk_in);
    endtask : idle

    task automatic chk(input logic got, input logic want);
        num_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("[ERR] %0t flag got %b want %b", $time, got, want);
        end
    endtask : chk

    always @(posedge sys_clk_in) rd_seen <= rd_in;

    always @(negedge sys_clk_in) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            num_checks++;
            if ((rdata_out >= e.lo && rdata_out <= e.hi) !== 1'b1) begin
                error_cnt++;
                $display("[ERR] %0t read %h want %h..%h", $time, rdata_out, e.lo, e.hi);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        error_cnt++;
        $display("[ERR] %0t run did not finish", $time);
        tally_and_finish();
    end

    initial begin
        void'($urandom(85));
        repeat (2) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        @(posedge sys_clk_in);
        for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00, 8'h00);
        for (int a = 2; a < 5; a++) begin
            v = 8'($urandom);
            wr(a[3:0], v);
            rd(a[3:0], v, v);
        end
        wr(ETC_OFF_COUNT, 8'h33);
        idle(20);
        rd(ETC_OFF_COUNT, 8'h33, 8'h33);
        wr(ETC_OFF_CMP_A, 8'h10);
        wr(ETC_OFF_CMP_B, 8'h80);
        wr(ETC_OFF_IRQ_FLAG, 8'h07);
        wr(ETC_OFF_COUNT, 8'hf4);
        wr(ETC_OFF_CTRL_B, 8'h01);
        idle(16);
        wr(ETC_OFF_CTRL_B, 8'h00);
        idle(4);
        rd(ETC_OFF_COUNT, 8'h00, 8'h08);
        rd(ETC_OFF_IRQ_FLAG, 8'h01, 8'h01);
        wr(ETC_OFF_IRQ_FLAG, 8'h00);
        rd(ETC_OFF_IRQ_FLAG, 8'h01, 8'h01);
        wr(ETC_OFF_IRQ_FLAG, 8'h01);
        rd(ETC_OFF_IRQ_FLAG, 8'h00, 8'h00);
        wr(ETC_OFF_CTRL_B, 8'h01);
        idle(6);
        wr(ETC_OFF_COUNT, 8'h40);
        rd(ETC_OFF_COUNT, 8'h40, 8'h40);
        wr(ETC_OFF_CTRL_B, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(ETC_OFF_COUNT, i ? 8'h7e : 8'h0e);
            wr(ETC_OFF_CTRL_B, 8'h01);
            idle(8);
            wr(ETC_OFF_CTRL_B, 8'h00);
            idle(4);
            v = i ? 8'h06 : 8'h02;
            rd(ETC_OFF_IRQ_FLAG, v, v);
        end
        idle(2);
        for (int i = 0; i < 3; i++) begin
            wr(ETC_OFF_IRQ_MASK, 8'h01 << i);
            idle(2);
            chk(irq_out, i != 0);
        end
        wr(ETC_OFF_IRQ_FLAG, 8'h04);
        idle(2);
        chk(irq_out, 1'b0);
        for (int s = 6; s < 8; s++) begin
            wr(ETC_OFF_COUNT, 8'h00);
            wr(ETC_OFF_CTRL_B, 8'(s));
            idle(4);
            repeat (5) begin
                ext_count_pin_in <= 1'b1;
                idle(8);
                ext_count_pin_in <= 1'b0;
                idle(8);
            end
            ext_count_pin_in <= 1'b1;
            idle(8);
            wr(ETC_OFF_CTRL_B, 8'h00);
            ext_count_pin_in <= 1'b0;
            idle(4);
            rd(ETC_OFF_COUNT, 8'(s - 1), 8'(s - 1));
        end
        for (int s = 2; s < 6; s++) begin
            wr(ETC_OFF_COUNT, 8'h00);
            wr(ETC_OFF_CTRL_B, 8'(s));
            idle(1040);
            wr(ETC_OFF_CTRL_B, 8'h00);
            idle(4);
            rd(ETC_OFF_COUNT, pre_exp[s-2] - 8'h01, pre_exp[s-2] + 8'h01);
        end
        wr(ETC_OFF_COUNT, 8'hff);
        idle(3);
        chk(max_out, 1'b1);
        chk(top_out, 1'b1);
        wr(ETC_OFF_COUNT, 8'h00);
        idle(3);
        chk(bottom_out, 1'b1);
        wr(ETC_OFF_CMP_A, 8'h05);
        wr(ETC_OFF_CTRL_A, 8'h02);
        wr(ETC_OFF_COUNT, 8'h05);
        idle(3);
        chk(top_out, 1'b1);
        chk(max_out, 1'b0);
        chk(wave_out_a_out, 1'b1);
        chk(wave_out_b_out, 1'b0);
        for (int i = 0; i < 2; i++) begin
            wr(ETC_OFF_COUNT, 8'h00);
            wr(ETC_OFF_CTRL_B, i ? 8'h09 : 8'h01);
            idle(40);
            wr(ETC_OFF_CTRL_B, 8'h00);
            idle(4);
            rd(ETC_OFF_COUNT, i ? 8'h24 : 8'h00, i ? 8'h30 : 8'h05);
        end
        // Phase-correct from 0xf0: up to max, then back down
        wr(ETC_OFF_COUNT, 8'hf0);
        wr(ETC_OFF_CTRL_A, 8'h01);
        wr(ETC_OFF_CTRL_B, 8'h01);
        idle(40);
        wr(ETC_OFF_CTRL_B, 8'h00);
        idle(4);
        rd(ETC_OFF_COUNT, 8'he2, 8'he8);
        // Fast mode with compare A as top wraps like CTC
        wr(ETC_OFF_COUNT, 8'h00);
        wr(ETC_OFF_CTRL_A, 8'h03);
        wr(ETC_OFF_CTRL_B, 8'h09);
        idle(40);
        wr(ETC_OFF_CTRL_B, 8'h00);
        idle(4);
        rd(ETC_OFF_COUNT, 8'h00, 8'h05);
        idle(4);
        tally_and_finish();
    end
endmodule : eight_bit_timer_counter_core_test
